// ===== hdl/irsr_defines.svh
// offsets, field positions, reset values and constants of the status block
`ifndef IRSR_DEFINES_SVH
`define IRSR_DEFINES_SVH

`define IRSR_ADDR_W            16
`define IRSR_DATA_W            32
`define IRSR_SRC_OFFSET        16'hF680
`define IRSR_CUR_OFFSET        16'hF6A0
`define IRSR_EVT_STATUS_OFFSET 16'hF6B0
`define IRSR_EVT_MASK_OFFSET   16'hF6B4

`define IRSR_PCI_ERR_BIT       22
`define IRSR_NAND_BIT          21
`define IRSR_RSVD_BIT          20
`define IRSR_TMR2_BIT          19
`define IRSR_TMR1_BIT          18
`define IRSR_TMR0_BIT          17
`define IRSR_PCI_CONTROLLER_BIT          16
`define IRSR_PCI_DMA_CONTROLLER_BIT         15
`define IRSR_OWN_BIT           14
`define IRSR_DMA_MSB           13
`define IRSR_DMA_LSB           10
`define IRSR_SRC_RST           32'h0000_0000

`define IRSR_FLAG_BIT          16
`define IRSR_LVL_MSB           10
`define IRSR_LVL_LSB           8
`define IRSR_CAUSE_MSB         4
`define IRSR_CAUSE_LSB         0
`define IRSR_FLAG_RST          1'h1
`define IRSR_LVL_RST           3'h0
`define IRSR_CAUSE_RST         5'h1F

`define IRSR_EVT_W             3
`define IRSR_EVT_REPORT        0
`define IRSR_EVT_SOURCE        1
`define IRSR_EVT_WITHDRAW      2
`define IRSR_EVT_RST           3'h0

`define IRSR_RESP_OKAY         2'h0
`define IRSR_RESP_SLVERR       2'h2

`endif

// ===== hdl/irsr_pkg.sv
// types shared by the interrupt status reporting block
package irsr_pkg;
   typedef struct packed {
      logic       no_request;
      logic [2:0] level;
      logic [4:0] cause;
   } irsr_report_t;

   typedef enum logic [4:0] {
      IRSR_CAUSE_MEM_ECC       = 5'h00,
      IRSR_CAUSE_WR_TIMEOUT    = 5'h01,
      IRSR_CAUSE_DMA_CH0       = 5'h0A,
      IRSR_CAUSE_OWN_SOURCE    = 5'h0E,
      IRSR_CAUSE_PCI_DMA       = 5'h0F,
      IRSR_CAUSE_PCI_CTRL      = 5'h10,
      IRSR_CAUSE_TIMER0        = 5'h11,
      IRSR_CAUSE_NAND_CTRL     = 5'h15,
      IRSR_CAUSE_PCI_ERROR     = 5'h16,
      IRSR_CAUSE_SERIAL_PERIPH = 5'h1F
   } irsr_cause_t;
endpackage

// ===== hdl/irsr_evt_if.sv
// event carrier between the register front end and the sticky status keeper
`timescale 1ns/1ps
interface irsr_evt_if #(
   parameter int W = 3
);
   logic [W-1:0] set;
   logic [W-1:0] clr;
   logic         mask_we;
   logic [W-1:0] mask_wdata;
   logic [W-1:0] status;
   logic [W-1:0] mask;

   modport front (output set, output clr, output mask_we,
                  output mask_wdata, input status, input mask);
   modport keeper (input set, input clr, input mask_we,
                   input mask_wdata, output status, output mask);
endinterface

// ===== hdl/irsr_src_sampler.sv
// registers the raw source request word and flags any new request
`timescale 1ns/1ps
`include "irsr_defines.svh"
module irsr_src_sampler #(
   parameter int W = 32
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] state,
   output logic              rise
);
   logic [W-1:0] next_state;

   assign next_state = raw;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= W'(`IRSR_SRC_RST);
      end else begin
         state <= next_state;
      end
   end

   // a source that goes from idle to requesting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rise <= 1'b0;
      end else begin
         rise <= |(next_state & ~state);
      end
   end
endmodule

// ===== hdl/irsr_irq_keeper.sv
// sticky event status, mask and the level interrupt output
`timescale 1ns/1ps
`include "irsr_defines.svh"
module irsr_irq_keeper #(
   parameter int W = 3
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   irsr_evt_if.keeper evt,
   output logic      irq
);
   logic [W-1:0] status_q;
   logic [W-1:0] mask_q;
   logic [W-1:0] next_status;
   logic [W-1:0] next_mask;

   assign evt.status = status_q;
   assign evt.mask   = mask_q;
   assign next_status = (status_q & ~evt.clr) | evt.set;
   assign next_mask   = evt.mask_we ? evt.mask_wdata : mask_q;

   // a set arriving with its clear wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= W'(`IRSR_EVT_RST);
      end else begin
         status_q <= next_status;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= W'(`IRSR_EVT_RST);
      end else if (evt.mask_we) begin
         mask_q <= evt.mask_wdata;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         // follows status and mask as they stand after this edge
         irq <= |(next_status & next_mask);
      end
   end
endmodule

// ===== hdl/irsr_top.sv
// interrupt status reporting registers behind an AXI4-Lite slave
// What this block does
// (RULE_01) Source bit 22 follows the PCI bus error, bit 21 the NAND unit.
// (RULE_02) Source bit 20 is reserved and never reports a request.
// (RULE_03) Source bits 19, 18, 17 follow timer channels 2, 1, 0.
// (RULE_04) Source bit 16 follows the PCI controller, bit 15 its DMA unit.
// (RULE_05) Source bit 14 follows the interrupt unit's own source.
// (RULE_06) Source bits 13 down to 10 follow DMA channels 3 down to 0.
// (RULE_07) A source bit reads 1 while requesting, else 0, and ignores writes.
// (RULE_08) Current bit 16 reads 0 once a request went out, else 1; resets 1.
// (RULE_09) Current bits 10:8 give the reported request's level 0 to 7.
// (RULE_10) Level and cause carry no meaning while bit 16 reads 1.
// (RULE_11) Level resets to 000; bits 31:17, 15:11, 7:5 reserved, read-only.
// (RULE_12) Bits 4:0 hold the read-only cause, reset value 11111.
// (RULE_13) The cause code names the reported source, 00000 to 11111.
// (RULE_14) Flag, level and cause move on one edge so one read is consistent.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "irsr_defines.svh"
module irsr_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // source request lines
   input  wire logic        pci_bus_error,
   input  wire logic        nand_flash_controller,
   input  wire logic [2:0]  timer_channel,
   input  wire logic        pci_controller,
   input  wire logic        pci_dma_controller,
   input  wire logic        interrupt_unit_source,
   input  wire logic [3:0]  dma_channel,
   // request currently forwarded to the core by the priority logic
   input  wire logic        core_req_pending,
   input  wire logic [2:0]  reported_priority_level,
   input  wire logic [4:0]  reported_cause,
   // interrupt
   output logic             irq
);
   localparam int AW = `IRSR_ADDR_W;
   localparam int DW = `IRSR_DATA_W;
   localparam int EW = `IRSR_EVT_W;

   // word-aligned register match
   function automatic logic addr_is(input logic [AW-1:0] a,
                                    input logic [AW-1:0] off);
      addr_is = (a[AW-1:2] == off[AW-1:2]);
   endfunction

   // one-hot select: source, current, event status, event mask
   function automatic logic [3:0] reg_sel(input logic [AW-1:0] a);
      reg_sel    = 4'h0;
      reg_sel[0] = addr_is(a, `IRSR_SRC_OFFSET);
      reg_sel[1] = addr_is(a, `IRSR_CUR_OFFSET);
      reg_sel[2] = addr_is(a, `IRSR_EVT_STATUS_OFFSET);
      reg_sel[3] = addr_is(a, `IRSR_EVT_MASK_OFFSET);
   endfunction

   function automatic logic addr_mapped(input logic [AW-1:0] a);
      addr_mapped = |reg_sel(a);
   endfunction

   //------------------------------------------------------------------
   // source request word
   //------------------------------------------------------------------
   logic [DW-1:0] src_raw;
   logic [DW-1:0] source_request_state;
   logic          src_rise;

   always_comb begin
      src_raw                             = '0;
      src_raw[`IRSR_PCI_ERR_BIT]          = pci_bus_error;         // [RULE_01]
      src_raw[`IRSR_NAND_BIT]             = nand_flash_controller; // [RULE_01]
      src_raw[`IRSR_RSVD_BIT]             = 1'b0;                  // [RULE_02]
      src_raw[`IRSR_TMR2_BIT]             = timer_channel[2];      // [RULE_03]
      src_raw[`IRSR_TMR1_BIT]             = timer_channel[1];      // [RULE_03]
      src_raw[`IRSR_TMR0_BIT]             = timer_channel[0];      // [RULE_03]
      src_raw[`IRSR_PCI_CONTROLLER_BIT]             = pci_controller;        // [RULE_04]
      src_raw[`IRSR_PCI_DMA_CONTROLLER_BIT]            = pci_dma_controller;    // [RULE_04]
      src_raw[`IRSR_OWN_BIT]              = interrupt_unit_source; // [RULE_05]
      src_raw[`IRSR_DMA_MSB:`IRSR_DMA_LSB] = dma_channel;          // [RULE_06]
   end

   // 1 while requesting, 0 otherwise; no write path reaches it [RULE_07]
   irsr_src_sampler #(
      .W (DW)
   ) u_src (
      .aclk    (aclk),
      .aresetn (aresetn),
      .raw     (src_raw),
      .state   (source_request_state),
      .rise    (src_rise)
   );

   //------------------------------------------------------------------
   // current request snapshot
   //------------------------------------------------------------------
   irsr_pkg::irsr_report_t current_report;
   irsr_pkg::irsr_report_t next_report;

   always_comb begin
      next_report.no_request = ~core_req_pending;        // [RULE_08]
      next_report.level      = reported_priority_level;  // [RULE_09]
      next_report.cause      = reported_cause;           // [RULE_13]
   end

   // a forwarded request moves all three fields on one edge [RULE_14]
   // with none forwarded only the flag moves: level and cause keep their
   // last or reset values, so reset values stay readable [RULE_10]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         current_report.no_request <= `IRSR_FLAG_RST;   // [RULE_08]
         current_report.level      <= `IRSR_LVL_RST;    // [RULE_11]
         current_report.cause      <= `IRSR_CAUSE_RST;  // [RULE_12]
      end else begin
         current_report.no_request <= next_report.no_request;
         if (core_req_pending) begin
            current_report.level <= next_report.level;
            current_report.cause <= next_report.cause;
         end
      end
   end

   logic [DW-1:0] current_interrupt_state;

   // reserved bits stay zero and take no write [RULE_11]
   always_comb begin
      current_interrupt_state = '0;
      current_interrupt_state[`IRSR_FLAG_BIT] = current_report.no_request;
      current_interrupt_state[`IRSR_LVL_MSB:`IRSR_LVL_LSB] =
         current_report.level;                            // [RULE_09]
      current_interrupt_state[`IRSR_CAUSE_MSB:`IRSR_CAUSE_LSB] =
         current_report.cause;                            // [RULE_12]
   end

   //------------------------------------------------------------------
   // events and interrupt
   //------------------------------------------------------------------
   irsr_evt_if #(.W(EW)) evt ();

   logic          report_prev;
   logic [EW-1:0] evt_set;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         report_prev <= 1'b0;
      end else begin
         report_prev <= ~current_report.no_request;
      end
   end

   always_comb begin
      evt_set                     = '0;
      evt_set[`IRSR_EVT_REPORT]   = ~current_report.no_request & ~report_prev;
      evt_set[`IRSR_EVT_SOURCE]   = src_rise;
      evt_set[`IRSR_EVT_WITHDRAW] = current_report.no_request & report_prev;
   end

   assign evt.set = evt_set;

   irsr_irq_keeper #(
      .W (EW)
   ) u_irq (
      .aclk    (aclk),
      .aresetn (aresetn),
      .evt     (evt),
      .irq     (irq)
   );

   //------------------------------------------------------------------
   // AXI4-Lite write path: address and data taken in either order
   //------------------------------------------------------------------
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic [3:0]    wr_strb;
   logic          aw_held;
   logic          w_held;
   logic          wr_fire;
   logic [1:0]    bresp_q;
   logic          bvalid_q;

   assign s_axi_awready = ~aw_held & ~bvalid_q;
   assign s_axi_wready  = ~w_held & ~bvalid_q;
   assign wr_fire       = aw_held & w_held & ~bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         wr_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         wr_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held  <= 1'b0;
         wr_data <= '0;
         wr_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held  <= 1'b1;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `IRSR_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= addr_mapped(wr_addr) ? `IRSR_RESP_OKAY
                                          : `IRSR_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // only the low byte lane reaches the event registers
   logic       wr_lane0;
   logic [3:0] wr_sel;

   assign wr_lane0 = wr_fire & wr_strb[0];
   assign wr_sel   = reg_sel(wr_addr);

   always_comb begin
      evt.clr = '0;
      if (wr_lane0 && wr_sel[2]) begin
         evt.clr = wr_data[EW-1:0];
      end
   end

   assign evt.mask_we    = wr_lane0 & wr_sel[3];
   assign evt.mask_wdata = wr_data[EW-1:0];

   //------------------------------------------------------------------
   // AXI4-Lite read path
   //------------------------------------------------------------------
   logic [DW-1:0] next_rdata;
   logic [1:0]    next_rresp;
   logic [DW-1:0] rdata_q;
   logic [1:0]    rresp_q;
   logic          rvalid_q;
   logic [3:0]    rd_sel;

   assign s_axi_arready = ~rvalid_q;
   assign rd_sel        = reg_sel(s_axi_araddr);

   always_comb begin
      next_rdata = '0;
      next_rresp = `IRSR_RESP_OKAY;
      case (rd_sel)
         4'h1: begin
            next_rdata = source_request_state;
         end
         4'h2: begin
            next_rdata = current_interrupt_state;
         end
         4'h4: begin
            next_rdata[EW-1:0] = evt.status;
         end
         4'h8: begin
            next_rdata[EW-1:0] = evt.mask;
         end
         default: begin
            next_rresp = `IRSR_RESP_SLVERR;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_q <= '0;
         rresp_q <= `IRSR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rdata_q <= next_rdata;
         rresp_q <= next_rresp;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // protection attributes carry no meaning here
   logic prot_unused;

   assign prot_unused = ^{s_axi_awprot, s_axi_arprot};
endmodule

// ===== dv/irsr_status_assertions.sv
// concurrent checks on the read side of the status registers
`timescale 1ns/1ps
module irsr_status_assertions (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [15:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        pci_bus_error,
   input wire logic        nand_flash_controller,
   input wire logic [2:0]  timer_channel,
   input wire logic        pci_controller,
   input wire logic        pci_dma_controller,
   input wire logic        interrupt_unit_source,
   input wire logic [3:0]  dma_channel,
   input wire logic        core_req_pending,
   input wire logic [2:0]  reported_priority_level,
   input wire logic [4:0]  reported_cause
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_rd_src;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 16'hF680;
   endsequence
   sequence s_rd_cur;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 16'hF6A0;
   endsequence
   // a read taken while a request was already forwarded
   sequence s_rd_pend;
      s_rd_cur ##0 $past(core_req_pending);
   endsequence

   a_src_pci_nand: assert property (
      s_rd_src |=> s_axi_rdata[22:21] == {$past(pci_bus_error, 2),
      $past(nand_flash_controller, 2)}) else $error("bad bits 22:21");
   a_src_reserved: assert property (
      s_rd_src |=> s_axi_rdata[20] == 1'b0) else $error("bit 20 set");
   a_src_timers: assert property (
      s_rd_src |=> s_axi_rdata[19:17] == $past(timer_channel, 2))
      else $error("bad timer bits");
   a_src_pci_ctl: assert property (
      s_rd_src |=> s_axi_rdata[16:15] == {$past(pci_controller, 2),
      $past(pci_dma_controller, 2)}) else $error("bad bits 16:15");
   a_src_own_bit: assert property (
      s_rd_src |=> s_axi_rdata[14] == $past(interrupt_unit_source, 2))
      else $error("bad bit 14");
   a_src_dma_bits: assert property (
      s_rd_src |=> s_axi_rdata[13:10] == $past(dma_channel, 2))
      else $error("bad dma bits");
   a_cur_flag: assert property (
      s_rd_cur |=> s_axi_rdata[16] == !$past(core_req_pending, 2))
      else $error("bad pending flag");
   a_cur_snapshot: assert property (
      s_rd_pend |=> {s_axi_rdata[10:8], s_axi_rdata[4:0]} ==
      {$past(reported_priority_level, 2), $past(reported_cause, 2)})
      else $error("bad level or cause");
   a_cur_reserved: assert property (
      s_rd_cur |=> s_axi_rdata[31:17] == 15'h0 &&
      s_axi_rdata[15:11] == 5'h0 && s_axi_rdata[7:5] == 3'h0)
      else $error("reserved bits set");
endmodule

bind irsr_top irsr_status_assertions u_irsr_status_assertions (.*);

// ===== dv/irsr_core_model.sv
// behavioural priority logic forwarding one request toward the core
`timescale 1ns/1ps
module irsr_core_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       go,
   input  wire logic [3:0] lag,
   input  wire logic [2:0] lvl,
   input  wire logic [4:0] cause,
   output logic            core_req_pending,
   output logic [2:0]      reported_priority_level,
   output logic [4:0]      reported_cause
);
   logic [3:0] cnt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt                     <= 4'h0;
         core_req_pending        <= 1'b0;
         reported_priority_level <= 3'h0;
         reported_cause          <= 5'h00;
      end else begin
         // fields churn while idle so nothing leans on stale values
         if (!core_req_pending) begin
            reported_priority_level <= reported_priority_level + 3'h1;
            reported_cause          <= reported_cause + 5'h01;
         end
         if (go && !core_req_pending && cnt >= lag) begin
            core_req_pending        <= 1'b1;
            reported_priority_level <= lvl;
            reported_cause          <= cause;
            cnt                     <= 4'h0;
         end else if (go && !core_req_pending) begin
            cnt <= cnt + 4'h1;
         end else if (!go) begin
            core_req_pending <= 1'b0;
            cnt              <= 4'h0;
         end
      end
   end
endmodule

// ===== dv/testbench.sv
// self-checking bench for the interrupt status registers
`timescale 1ns/1ps
module testbench;
   logic        aclk, aresetn, irq, go;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot, reported_priority_level, lvl;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, lag;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, core_req_pending;
   logic [11:0] src;
   logic [4:0]  reported_cause, cause;
   int          err_total, n_compared, cycles;

   irsr_top u_irsr_top (.*, .pci_bus_error(src[11]),
      .nand_flash_controller(src[10]), .timer_channel(src[9:7]),
      .pci_controller(src[6]), .pci_dma_controller(src[5]),
      .interrupt_unit_source(src[4]), .dma_channel(src[3:0]));
   irsr_core_model u_irsr_core_model (.*);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic stop_test;
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         stop_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      check(d, e);
      check({30'h0, r}, 32'h0);
   endtask

   task automatic wait_pend(input logic v);
      while (core_req_pending !== v) @(posedge aclk);
      repeat (2) @(posedge aclk);
   endtask

   task automatic t_reset;
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(16'hF680, 32'h0);
      rd_chk(16'hF6A0, 32'h0001_001F);
      check({31'h0, irq}, 32'h0);
      $display("reset test done");
   endtask

   task automatic t_sources;
      logic [11:0] s;
      logic [31:0] d, e;
      logic [1:0]  r;
      for (int i = 0; i <= 12; i++) begin
         s = (i == 12) ? 12'hFFF : 12'h001 << i;
         src <= s;
         e = {9'h0, s[11:10], 1'b0, s[9:0], 10'h0};
         wr(16'hF680, 32'hFFFF_FFFF, 2'h0);
         rd(16'hF680, d, r);
         check(d, e);
         check({25'h0, d[16:10]}, {25'h0, e[16:10]});
         check({31'h0, d[14]}, {31'h0, s[4]});
      end
      src <= 12'h0;
      $display("source test done");
   endtask

   task automatic t_current;
      logic [31:0] d;
      logic [1:0]  r;
      logic [4:0]  c;
      for (int i = 0; i < 32; i++) begin
         c = 5'(i);
         lag   <= c[0] ? 4'h5 : 4'h0;
         lvl   <= c[2:0];
         cause <= c;
         go    <= 1'b1;
         wait_pend(1'b1);
         rd(16'hF6A0, d, r);
         check(d, {21'h0, c[2:0], 3'h0, c});
         go <= 1'b0;
         wait_pend(1'b0);
         wr(16'hF6A0, 32'h0, 2'h0);
         rd(16'hF6A0, d, r);
         check({31'h0, d[16]}, 32'h1);
      end
      $display("current state test done");
   endtask

   task automatic t_events;
      logic [31:0] d;
      logic [1:0]  r;
      wr(16'hF6B0, 32'h7, 2'h0);
      rd_chk(16'hF6B0, 32'h0);
      lag <= 4'h0;
      go  <= 1'b1;
      wait_pend(1'b1);
      rd_chk(16'hF6B0, 32'h1);
      check({31'h0, irq}, 32'h0);
      wr(16'hF6B4, 32'h7, 2'h0);
      rd_chk(16'hF6B4, 32'h7);
      check({31'h0, irq}, 32'h1);
      wr(16'hF6B0, 32'h1, 2'h0);
      rd_chk(16'hF6B0, 32'h0);
      check({31'h0, irq}, 32'h0);
      go <= 1'b0;
      wait_pend(1'b0);
      rd_chk(16'hF6B0, 32'h4);
      check({31'h0, irq}, 32'h1);
      wr(16'hF6B0, 32'h4, 2'h0);
      rd_chk(16'hF6B0, 32'h0);
      src <= 12'h001;
      repeat (2) @(posedge aclk);
      rd_chk(16'hF6B0, 32'h2);
      check({31'h0, irq}, 32'h1);
      wr(16'hF6B0, 32'h2, 2'h0);
      rd_chk(16'hF6B0, 32'h0);
      check({31'h0, irq}, 32'h0);
      src <= 12'h000;
      wr(16'h0000, 32'h0, 2'h2);
      rd(16'h0000, d, r);
      check(d, 32'h0);
      check({30'h0, r}, 32'h2);
      $display("event test done");
   endtask

   initial begin
      {aresetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {src, lag, lvl, cause, err_total, n_compared, cycles} = '0;
      s_axi_wstrb = 4'hF;
      t_reset();
      t_sources();
      t_current();
      t_events();
      t_reset();
      stop_test();
   end
endmodule
